/* shared/pwrsc_pkg.sv */
// Shared constants and types for the power-state and reset controller.
package pwrsc_pkg;
    // Bit positions of the conditioned pin levels.
    localparam int PIN_MAIN = 0;
    localparam int PIN_EN   = 1;
    localparam int PIN_IREG = 2;
    localparam int PIN_DRV  = 3;
    localparam int PIN_DIG  = 4;
    localparam int PIN_LIMP = 5;
    localparam int PIN_DIM  = 6;
    localparam int PIN_BST  = 7;
    localparam int PIN_W    = 9;
    // Filtered state inputs: the six supply and limp levels plus standby.
    localparam int LVL_STBY = 6;
    localparam int LVL_W    = 7;
    // Longest filter time in clock cycles, and the equal compares it needs.
    localparam int         FILT_MAX_CYC = 3;
    localparam logic [1:0] FILT_HOLD    = 2'(FILT_MAX_CYC - 1);
    // Values forced by reset.
    localparam logic TER_RST   = 1'b1;
    localparam logic RRST_RST  = 1'b1;
    localparam logic [PIN_W-1:0] PIN_RST = 9'h000;

    typedef enum logic [3:0] {
        PWRSC_SLEEP  = 4'h1,
        PWRSC_IDLE   = 4'h2,
        PWRSC_LIMP   = 4'h4,
        PWRSC_ACTIVE = 4'h8
    } pwrsc_state_type;
endpackage : pwrsc_pkg

/* logic/pwrsc_power_ctrl.sv */
// Power-state selection, switching gate and register reset control.
`timescale 1ns/100ps
//
// Contract
// - Pick state from filtered supply, enable, limp and standby levels, filter at most 3 cycles.
// - Sleep keeps all outputs off and register bank in reset.
// - Idle never switches the gate drivers; regulator stays on.
// - Idle with digital supply present keeps registers and serial access working.
// - Entering limp home resets every register to default.
// - Limp home allows reads but blocks every register write.
// - Active switches only while the dimming input is high.
// - Each high-side driver runs only with its bootstrap level above threshold.
// - Any reset sets the transmission error flag to one.
// - Enable pin low: serial port off, registers reset, enter sleep.
// - Digital supply low: no driver activation, no serial access, registers reset.
// - Driver or regulator supply low stops switching, registers untouched.
// - Enable undervoltage also turns the internal regulator off.
// - Software reset bit restores all writable registers.
// - Software reset spares the calibration result; readable with calibration enable.
module pwrsc_power_ctrl
    import pwrsc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       main_supply_i,
    input  wire logic       enable_undervoltage_pin_i,
    input  wire logic       internal_regulator_output_i,
    input  wire logic       driver_supply_input_i,
    input  wire logic       digital_supply_i,
    input  wire logic       limp_home_input_i,
    input  wire logic       dimming_input_i,
    input  wire logic [1:0] bootstrap_ok_i,
    input  wire logic       standby_request_bit_i,
    input  wire logic       software_reset_bit_i,
    input  wire logic       calibration_enable_bit_i,
    input  wire logic       ter_clear_i,
    output logic      [3:0] power_state_o,
    output logic            reg_reset_o,
    output logic            cal_reset_o,
    output logic            serial_access_o,
    output logic            write_allow_o,
    output logic            cal_read_o,
    output logic            regulator_enable_o,
    output logic            switch_enable_o,
    output logic      [1:0] high_side_drivers_o,
    output logic            transmission_error_flag_o
);

    // Input conditioning: three-stage synchroniser, agreement, level filter.
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [PIN_W-1:0] agree_reg, agree_next;
    logic [LVL_W-1:0] lvl_now;
    logic [LVL_W-1:0] lvl_prev_reg, lvl_prev_next;
    logic [LVL_W-1:0] lvl_filt_reg, lvl_filt_next;
    logic [1:0]       cnt_reg, cnt_next;

    assign pin_raw = {bootstrap_ok_i, dimming_input_i, limp_home_input_i, digital_supply_i,
                      driver_supply_input_i, internal_regulator_output_i,
                      enable_undervoltage_pin_i, main_supply_i};
    assign lvl_now = {standby_request_bit_i, agree_reg[PIN_LIMP:PIN_MAIN]};

    always_comb begin
        // A pin change is taken only once stages two and three agree.
        agree_next    = (sync3_reg & ~(sync2_reg ^ sync3_reg))
                      | (agree_reg & (sync2_reg ^ sync3_reg));
        lvl_prev_next = lvl_now;
        if (lvl_now == lvl_prev_reg) begin
            cnt_next = (cnt_reg == FILT_HOLD) ? cnt_reg : cnt_reg + 2'h1;
        end else begin
            cnt_next = 2'h0;
        end
        // The state logic sees a level only after it held for the filter time.
        lvl_filt_next = (cnt_next == FILT_HOLD) ? lvl_now : lvl_filt_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sync1_reg    <= PIN_RST;
            sync2_reg    <= PIN_RST;
            sync3_reg    <= PIN_RST;
            agree_reg    <= PIN_RST;
            lvl_prev_reg <= '0;
            lvl_filt_reg <= '0;
            cnt_reg      <= 2'h0;
        end else begin
            sync1_reg    <= pin_raw;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            agree_reg    <= agree_next;
            lvl_prev_reg <= lvl_prev_next;
            lvl_filt_reg <= lvl_filt_next;
            cnt_reg      <= cnt_next;
        end
    end

    // Power state and everything derived from it.
    pwrsc_state_type state_reg, state_next;
    logic       rrst_reg, rrst_next;
    logic       crst_reg, crst_next;
    logic       access_reg, access_next;
    logic       write_reg, write_next;
    logic       calrd_reg, calrd_next;
    logic       ldo_reg, ldo_next;
    logic       sw_reg, sw_next;
    logic [1:0] hs_reg, hs_next;
    logic       ter_reg, ter_next;
    logic       en, main_ok, ireg_ok, drv_ok, dig_ok, limp, stby, limp_entry;

    always_comb begin
        main_ok = lvl_filt_reg[PIN_MAIN];
        en      = lvl_filt_reg[PIN_EN];
        ireg_ok = lvl_filt_reg[PIN_IREG];
        drv_ok  = lvl_filt_reg[PIN_DRV];
        dig_ok  = lvl_filt_reg[PIN_DIG];
        limp    = lvl_filt_reg[PIN_LIMP];
        stby    = lvl_filt_reg[LVL_STBY];
        if (!en || !main_ok) begin
            state_next = PWRSC_SLEEP;
        end else if (limp) begin
            state_next = PWRSC_LIMP;
        end else if (stby) begin
            state_next = PWRSC_IDLE;
        end else begin
            state_next = PWRSC_ACTIVE;
        end
        limp_entry = (state_next == PWRSC_LIMP) && (state_reg != PWRSC_LIMP);
        // Calibration storage only follows the hard sources, never software reset.
        crst_next  = !en || !dig_ok || (state_next == PWRSC_SLEEP) || limp_entry;
        rrst_next  = crst_next || software_reset_bit_i;
        access_next = en && dig_ok && (state_next != PWRSC_SLEEP);
        write_next  = access_next && (state_next != PWRSC_LIMP);
        calrd_next  = access_next && calibration_enable_bit_i;
        ldo_next    = en && (state_next != PWRSC_SLEEP);
        // Limp home keeps regulating from the backup path under the same gates.
        sw_next = ((state_next == PWRSC_ACTIVE) || (state_next == PWRSC_LIMP))
                && agree_reg[PIN_DIM] && dig_ok && ireg_ok && drv_ok;
        hs_next = {2{sw_next}} & agree_reg[PIN_BST +: 2];
        // Set beats a simultaneous clear so a reset is never missed.
        if (rrst_next) begin
            ter_next = 1'b1;
        end else if (ter_clear_i) begin
            ter_next = 1'b0;
        end else begin
            ter_next = ter_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg  <= PWRSC_SLEEP;
            rrst_reg   <= RRST_RST;
            crst_reg   <= RRST_RST;
            access_reg <= 1'b0;
            write_reg  <= 1'b0;
            calrd_reg  <= 1'b0;
            ldo_reg    <= 1'b0;
            sw_reg     <= 1'b0;
            hs_reg     <= 2'h0;
            ter_reg    <= TER_RST;
        end else begin
            state_reg  <= state_next;
            rrst_reg   <= rrst_next;
            crst_reg   <= crst_next;
            access_reg <= access_next;
            write_reg  <= write_next;
            calrd_reg  <= calrd_next;
            ldo_reg    <= ldo_next;
            sw_reg     <= sw_next;
            hs_reg     <= hs_next;
            ter_reg    <= ter_next;
        end
    end

    assign power_state_o             = state_reg;
    assign reg_reset_o               = rrst_reg;
    assign cal_reset_o               = crst_reg;
    assign serial_access_o           = access_reg;
    assign write_allow_o             = write_reg;
    assign cal_read_o                = calrd_reg;
    assign regulator_enable_o        = ldo_reg;
    assign switch_enable_o           = sw_reg;
    assign high_side_drivers_o       = hs_reg;
    assign transmission_error_flag_o = ter_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_filter_hold;
        $changed(lvl_filt_reg) |-> ($past(lvl_now, 1) == lvl_filt_reg)
            && ($past(lvl_now, 2) == lvl_filt_reg) && ($past(lvl_now, 3) == lvl_filt_reg);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("level filter too short");

    property p_sleep_quiet;
        (state_reg == PWRSC_SLEEP) |-> !switch_enable_o && !serial_access_o
            && reg_reset_o && !regulator_enable_o && (high_side_drivers_o == 2'h0);
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep not quiet");

    property p_idle_still;
        (state_reg == PWRSC_IDLE) |-> !switch_enable_o && regulator_enable_o;
    endproperty
    a_idle_still: assert property (p_idle_still) else $error("idle switching");

    property p_idle_access;
        (state_reg == PWRSC_IDLE) && $past(lvl_filt_reg[PIN_DIG])
            |-> (serial_access_o && write_allow_o && !reg_reset_o)
                || $past(software_reset_bit_i);
    endproperty
    a_idle_access: assert property (p_idle_access) else $error("idle access lost");

    sequence s_limp_entry;
        (state_reg != PWRSC_LIMP) ##1 (state_reg == PWRSC_LIMP);
    endsequence
    property p_limp_reset;
        s_limp_entry |-> reg_reset_o && cal_reset_o && transmission_error_flag_o;
    endproperty
    a_limp_reset: assert property (p_limp_reset) else $error("limp entry no reset");

    property p_limp_readonly;
        (state_reg == PWRSC_LIMP) |-> !write_allow_o ##1
            ((state_reg != PWRSC_LIMP) || !write_allow_o);
    endproperty
    a_limp_readonly: assert property (p_limp_readonly) else $error("limp write open");

    property p_dim_gate;
        switch_enable_o |-> $past(agree_reg[PIN_DIM]) && $past(lvl_filt_reg[PIN_IREG])
            && $past(lvl_filt_reg[PIN_DRV]) && $past(lvl_filt_reg[PIN_DIG]);
    endproperty
    a_dim_gate: assert property (p_dim_gate) else $error("switching ungated");

    property p_boot_gate;
        (high_side_drivers_o & ~$past(agree_reg[PIN_BST +: 2])) == 2'h0
            && ((high_side_drivers_o == 2'h0) || switch_enable_o);
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("high side ungated");

    property p_ter_set;
        reg_reset_o |-> transmission_error_flag_o ##1
            (transmission_error_flag_o || !$past(reg_reset_o) || $past(ter_clear_i));
    endproperty
    a_ter_set: assert property (p_ter_set) else $error("error flag not set");

    property p_en_low;
        !$past(lvl_filt_reg[PIN_EN]) |-> (state_reg == PWRSC_SLEEP) && reg_reset_o
            && !serial_access_o && !regulator_enable_o;
    endproperty
    a_en_low: assert property (p_en_low) else $error("enable low ignored");

    property p_dig_low;
        !$past(lvl_filt_reg[PIN_DIG]) |-> reg_reset_o && !serial_access_o
            && !switch_enable_o && (high_side_drivers_o == 2'h0);
    endproperty
    a_dig_low: assert property (p_dig_low) else $error("digital supply low ignored");

    property p_swrst;
        software_reset_bit_i |=> reg_reset_o;
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset lost");

    property p_cal_keep;
        reg_reset_o && !cal_reset_o |-> $past(software_reset_bit_i);
    endproperty
    a_cal_keep: assert property (p_cal_keep) else $error("calibration wrongly kept");

    property p_one_reset;
        cal_reset_o |-> reg_reset_o;
    endproperty
    a_one_reset: assert property (p_one_reset) else $error("reset sources split");

    property p_main_low;
        !$past(lvl_filt_reg[PIN_MAIN]) |-> (state_reg == PWRSC_SLEEP) && reg_reset_o;
    endproperty
    a_main_low: assert property (p_main_low) else $error("main supply low ignored");

    property p_write_gate;
        write_allow_o |-> serial_access_o && (state_reg != PWRSC_LIMP);
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("write open without access");

    property p_limp_read;
        (state_reg == PWRSC_LIMP) && $past(lvl_filt_reg[PIN_DIG]) |-> serial_access_o;
    endproperty
    a_limp_read: assert property (p_limp_read) else $error("limp reads blocked");

    property p_ter_clear;
        $past(ter_clear_i) && !reg_reset_o |-> !transmission_error_flag_o;
    endproperty
    a_ter_clear: assert property (p_ter_clear) else $error("error flag not cleared");

    property p_cal_read;
        cal_read_o |-> serial_access_o && $past(calibration_enable_bit_i);
    endproperty
    a_cal_read: assert property (p_cal_read) else $error("calibration read ungated");

    // Dips on the driver or regulator supply alone must never disturb the register bank.
    property p_reg_keep;
        $past(lvl_filt_reg[PIN_EN]) && $past(lvl_filt_reg[PIN_MAIN])
            && $past(lvl_filt_reg[PIN_DIG]) && !$past(software_reset_bit_i)
            && ((state_reg != PWRSC_LIMP) || ($past(state_reg) == PWRSC_LIMP))
            |-> !reg_reset_o;
    endproperty
    a_reg_keep: assert property (p_reg_keep) else $error("register bank reset");

endmodule : pwrsc_power_ctrl

/* dv/pwrsc_mcu_model.sv */
// Microcontroller-side model driving the supply monitors, pins and control bits.
`timescale 1ns/100ps
module pwrsc_mcu_model
    import pwrsc_pkg::*;
(
    output logic [PIN_W-1:0] pins_o,
    output logic             standby_o,
    output logic             swrst_o,
    output logic             cal_en_o,
    output logic             ter_clear_o
);
    initial begin
        pins_o = PIN_RST;
        {ter_clear_o, cal_en_o, swrst_o, standby_o} = 4'h0;
    end
    // Callers step only just after a falling edge, so no level moves near a sampling edge.
    task automatic set_pins(input logic [PIN_W-1:0] lv);
        pins_o = lv;
    endtask : set_pins
    // A single-cycle high on the reset bit stands for one register write of that bit.
    task automatic set_bits(input logic [3:0] b);
        {ter_clear_o, cal_en_o, swrst_o, standby_o} = b;
    endtask : set_bits
endmodule : pwrsc_mcu_model

/* dv/power_state_and_reset_control_tb.sv */
// Self-checking bench for the power-state and reset controller.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module power_state_and_reset_control_tb;
    import pwrsc_pkg::*;
    logic             ref_clk_i;
    logic             rst_n_i;
    logic [PIN_W-1:0] pins;
    logic             stby;
    logic             swrst;
    logic             cal_en;
    logic             ter_clr;
    logic [3:0]       state;
    logic             rr;
    logic             cr;
    logic             sa;
    logic             wa;
    logic             cd;
    logic             re;
    logic             se;
    logic             transmission_error_flag;
    logic [1:0]       hsd;
    int               err_total = 0;
    int               checks = 0;
    int               pulses;
    wire              main_lvl   = pins[PIN_MAIN];
    wire              enable_lvl = pins[PIN_EN];
    wire              ireg_lvl   = pins[PIN_IREG];
    wire              drv_lvl    = pins[PIN_DRV];
    wire              dig_lvl    = pins[PIN_DIG];
    wire              limp_lvl   = pins[PIN_LIMP];
    wire              dim_lvl    = pins[PIN_DIM];
    wire  [1:0]       boot_lvl   = pins[PIN_BST +: 2];
    wire  [10:0]      obs = {state, rr, sa, wa, re, se, hsd};

    pwrsc_mcu_model u_mcu (.pins_o(pins), .standby_o(stby), .swrst_o(swrst),
        .cal_en_o(cal_en), .ter_clear_o(ter_clr));

    pwrsc_power_ctrl uut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .main_supply_i(main_lvl), .enable_undervoltage_pin_i(enable_lvl),
        .internal_regulator_output_i(ireg_lvl), .driver_supply_input_i(drv_lvl),
        .digital_supply_i(dig_lvl), .limp_home_input_i(limp_lvl),
        .dimming_input_i(dim_lvl), .bootstrap_ok_i(boot_lvl),
        .standby_request_bit_i(stby), .software_reset_bit_i(swrst),
        .calibration_enable_bit_i(cal_en), .ter_clear_i(ter_clr),
        .power_state_o(state), .reg_reset_o(rr), .cal_reset_o(cr), .serial_access_o(sa),
        .write_allow_o(wa), .cal_read_o(cd), .regulator_enable_o(re), .switch_enable_o(se),
        .high_side_drivers_o(hsd), .transmission_error_flag_o(transmission_error_flag));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // Pin changes need eight edges to reach the outputs; ten leaves margin.
    task automatic go(input logic [PIN_W-1:0] p, input logic [10:0] e);
        u_mcu.set_pins(p);
        repeat (10) @(negedge ref_clk_i);
        `CHK(obs, e)
    endtask : go

    task automatic clear_ter;
        u_mcu.set_bits(4'h8);
        @(negedge ref_clk_i);
        u_mcu.set_bits(4'h0);
        `CHK(transmission_error_flag, 1'b0)
    endtask : clear_ter

    initial begin
        rst_n_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK(obs, {PWRSC_SLEEP, 7'h40})
        `CHK(transmission_error_flag, 1'b1)
        $display("test reset done");
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        clear_ter();
        go(9'h19f, {PWRSC_ACTIVE, 7'h38});
        go(9'h0df, {PWRSC_ACTIVE, 7'h3d});
        go(9'h15f, {PWRSC_ACTIVE, 7'h3e});
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        $display("test active done");
        u_mcu.set_bits(4'h4);
        @(negedge ref_clk_i);
        u_mcu.set_bits(4'h6);
        @(negedge ref_clk_i);
        u_mcu.set_bits(4'h4);
        `CHK(rr, 1'b1)
        `CHK(transmission_error_flag, 1'b1)
        `CHK(cr, 1'b0)
        `CHK(cd, 1'b1)
        @(negedge ref_clk_i);
        `CHK(rr, 1'b0)
        clear_ter();
        `CHK(cd, 1'b0)
        $display("test software reset done");
        go(9'h1d7, {PWRSC_ACTIVE, 7'h38});
        go(9'h1db, {PWRSC_ACTIVE, 7'h38});
        go(9'h1cf, {PWRSC_ACTIVE, 7'h48});
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        $display("test undervoltage done");
        u_mcu.set_bits(4'h1);
        repeat (10) @(negedge ref_clk_i);
        `CHK(obs, {PWRSC_IDLE, 7'h38})
        u_mcu.set_bits(4'h0);
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        // A two-cycle dip is shorter than the filter; a passing sleep would set the flag.
        clear_ter();
        u_mcu.set_pins(9'h1dd);
        repeat (2) @(negedge ref_clk_i);
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        `CHK(transmission_error_flag, 1'b0)
        $display("test idle and filter done");
        clear_ter();
        u_mcu.set_pins(9'h1ff);
        pulses = 0;
        repeat (12) begin
            @(negedge ref_clk_i);
            if (rr === 1'b1)
                pulses++;
        end
        `CHK(pulses, 1)
        `CHK(obs, {PWRSC_LIMP, 7'h2f})
        `CHK(transmission_error_flag, 1'b1)
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        $display("test limp done");
        // A mid-run reset must bring back sleep and the error flag.
        clear_ter();
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK(obs, {PWRSC_SLEEP, 7'h40})
        `CHK(transmission_error_flag, 1'b1)
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        go(9'h1de, {PWRSC_SLEEP, 7'h40});
        go(9'h1df, {PWRSC_ACTIVE, 7'h3f});
        go(9'h1dd, {PWRSC_SLEEP, 7'h40});
        $display("test reset and sleep done");
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge ref_clk_i);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : power_state_and_reset_control_tb
